// [rtl/cods_pkg.sv]
// Package for the opcode decode and string-suppression block
package cods_pkg;

	// Avalon register offsets (byte addresses)
	localparam logic [3:0] CODS_OFF_CTRL   = 4'h0;
	localparam logic [3:0] CODS_OFF_OPCODE = 4'h4;
	localparam logic [3:0] CODS_OFF_STATUS = 4'h8;
	localparam logic [3:0] CODS_OFF_DECODE = 4'hc;

	// Control register fields
	localparam int CODS_CTRL_EN_BIT    = 0;
	localparam int CODS_CTRL_IRQ_BIT   = 1;
	localparam int CODS_CTRL_RETI_BIT  = 2;
	localparam int CODS_CTRL_SECOND_BIT = 3;

	// Clock divider
	localparam int         CODS_OSC_DIV     = 4;
	localparam logic [1:0] CODS_DIV_LAST    = 2'(CODS_OSC_DIV - 1);

	// Reset values
	localparam logic [7:0] CODS_CTRL_RST    = 8'h00;

	// Opcode patterns
	localparam logic [4:0] CODS_OP_MOV_AR   = 5'b00001;
	localparam logic [4:0] CODS_OP_MOV_RA   = 5'b00011;
	localparam logic [4:0] CODS_OP_MVJ      = 5'b01101;
	localparam logic [4:0] CODS_OP_STX      = 5'b00111;
	localparam logic [4:0] CODS_OP_LDX      = 5'b00101;
	localparam logic [7:0] CODS_OP_STORE_WORK_AREA     = 8'h38;
	localparam logic [7:0] CODS_OP_LOAD_WORK_AREA     = 8'h28;
	localparam logic [7:0] CODS_PFX_SRW     = 8'h4d;
	localparam logic [7:0] CODS_PFX_SRR     = 8'h4c;
	localparam logic [7:0] CODS_PFX_DIR     = 8'h70;
	localparam logic [7:0] CODS_PFX_STK     = 8'h48;
	localparam logic [7:0] CODS_PFX_ALUR    = 8'h60;
	localparam logic [7:0] CODS_PFX_ALUX    = 8'h70;
	localparam logic [7:0] CODS_OP_LXI_H    = 8'h34;
	localparam logic [7:0] CODS_OP_MVI_A    = 8'h69;
	localparam logic [7:0] CODS_OP_MVI_L    = 8'h6f;

	// Clock counts
	localparam logic [4:0] CODS_CLK_MOV    = 5'd4;
	localparam logic [4:0] CODS_CLK_IMM    = 5'd7;
	localparam logic [4:0] CODS_CLK_SR     = 5'd10;
	localparam logic [4:0] CODS_CLK_LXI    = 5'd10;
	localparam logic [4:0] CODS_CLK_DIR    = 5'd17;
	localparam logic [4:0] CODS_CLK_PAIR   = 5'd20;
	localparam logic [4:0] CODS_CLK_PUSH   = 5'd17;
	localparam logic [4:0] CODS_CLK_POP    = 5'd14;
	localparam logic [4:0] CODS_CLK_ALUR   = 5'd8;
	localparam logic [4:0] CODS_CLK_ALUX   = 5'd11;
	localparam logic [4:0] CODS_CLK_UNK    = 5'd4;

	typedef enum logic [3:0] {
		CODS_REG_NONE = 4'b0000,
		CODS_REG_A    = 4'b0001,
		CODS_REG_B    = 4'b0010,
		CODS_REG_C    = 4'b0011,
		CODS_REG_D    = 4'b0100,
		CODS_REG_E    = 4'b0101,
		CODS_REG_H    = 4'b0110,
		CODS_REG_L    = 4'b0111
	} cods_reg_t;

	typedef enum logic [3:0] {
		CODS_SR_PA    = 4'b0000,
		CODS_SR_PB    = 4'b0001,
		CODS_SR_PC    = 4'b0010,
		CODS_SR_MASK  = 4'b0011,
		CODS_SR_PBDIR = 4'b0100,
		CODS_SR_TMR   = 4'b0110,
		CODS_SR_SHIFT = 4'b1000,
		CODS_SR_TMODE = 4'b1001,
		CODS_SR_SMODE = 4'b1010,
		CODS_SR_STBY  = 4'b1011,
		CODS_SR_NONE  = 4'b1111
	} cods_sr_t;

	typedef enum logic [2:0] {
		CODS_PR_SP   = 3'b000,
		CODS_PR_BC   = 3'b001,
		CODS_PR_DE   = 3'b010,
		CODS_PR_HL   = 3'b011,
		CODS_PR_FFA  = 3'b100
	} cods_pair_t;

	typedef enum logic [3:0] {
		CODS_IND_NONE = 4'b0000,
		CODS_IND_BC   = 4'b0001,
		CODS_IND_DE   = 4'b0010,
		CODS_IND_HL   = 4'b0011,
		CODS_IND_DEI  = 4'b0100,
		CODS_IND_HLI  = 4'b0101,
		CODS_IND_DED  = 4'b0110,
		CODS_IND_HLD  = 4'b0111
	} cods_ind_t;

	typedef enum logic [2:0] {
		CODS_IF_LEVEL  = 3'b000,
		CODS_IF_TIMER  = 3'b001,
		CODS_IF_EDGE   = 3'b010,
		CODS_IF_SERIAL = 3'b100,
		CODS_IF_NONE   = 3'b111
	} cods_irqf_t;

	typedef enum logic [1:0] {
		CODS_CF_CARRY = 2'b01,
		CODS_CF_ZERO  = 2'b10,
		CODS_CF_NONE  = 2'b00
	} cods_cond_t;

	typedef enum logic [1:0] {
		CODS_ST_IDLE = 2'b00,
		CODS_ST_RUN  = 2'b01,
		CODS_ST_SKIP = 2'b10
	} cods_state_t;

	// Decoded fields of the last instruction
	typedef struct packed {
		cods_reg_t  reg_sel;
		cods_sr_t   special_reg_field;
		cods_pair_t stack_pair_field;
		cods_ind_t  ind_sel;
		cods_irqf_t irqf_sel;
		cods_cond_t cond_sel;
		logic [4:0] clocks;
		logic       first_fetch_strobe;
	} cods_dec_t;

	typedef struct packed {
		cods_state_t state;
		logic [1:0]  div;
		logic [4:0]  cnt;
		logic [7:0]  ctrl;
		logic [7:0]  op1;
		logic [7:0]  op2;
		logic        acc_string_flag;
		logic        hl_string_flag;
		logic [1:0]  saved_flags;
		logic        suppressed;
		logic        irq_seen;
		logic [7:0]  rdata;
		logic        rvalid;
		cods_dec_t   dec;
	} cods_state_s_t;

endpackage

// [rtl/cods_decode.sv]
// Opcode decoder with instruction string suppression, Avalon-MM control
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
module cods_decode (
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic [3:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	output logic                   sys_tick,
	output logic                   busy,
	output cods_pkg::cods_dec_t    dec_out
);
	import cods_pkg::*;

	cods_state_s_t s_r;
	cods_state_s_t s_nxt;

	function automatic cods_reg_t dec_reg(input logic [2:0] f);
		unique case (f)
			3'b001: dec_reg = CODS_REG_A;
			3'b010: dec_reg = CODS_REG_B;
			3'b011: dec_reg = CODS_REG_C;
			3'b100: dec_reg = CODS_REG_D;
			3'b101: dec_reg = CODS_REG_E;
			3'b110: dec_reg = CODS_REG_H;
			3'b111: dec_reg = CODS_REG_L;
			default: dec_reg = CODS_REG_NONE;
		endcase
	endfunction

	function automatic cods_ind_t dec_ind(input logic [2:0] f);
		dec_ind = (f == 3'b000) ? CODS_IND_NONE : cods_ind_t'({1'b0, f});
	endfunction

	function automatic cods_sr_t dec_sr(input logic [3:0] f);
		unique case (f)
			4'b0000: dec_sr = CODS_SR_PA;
			4'b0001: dec_sr = CODS_SR_PB;
			4'b0010: dec_sr = CODS_SR_PC;
			4'b0011: dec_sr = CODS_SR_MASK;
			4'b0100: dec_sr = CODS_SR_PBDIR;
			4'b0110: dec_sr = CODS_SR_TMR;
			4'b1000: dec_sr = CODS_SR_SHIFT;
			4'b1001: dec_sr = CODS_SR_TMODE;
			4'b1010: dec_sr = CODS_SR_SMODE;
			4'b1011: dec_sr = CODS_SR_STBY;
			default: dec_sr = CODS_SR_NONE;
		endcase
	endfunction

	function automatic cods_irqf_t dec_irqf(input logic [2:0] f);
		unique case (f)
			3'b000: dec_irqf = CODS_IF_LEVEL;
			3'b001: dec_irqf = CODS_IF_TIMER;
			3'b010: dec_irqf = CODS_IF_EDGE;
			3'b100: dec_irqf = CODS_IF_SERIAL;
			default: dec_irqf = CODS_IF_NONE;
		endcase
	endfunction

	function automatic cods_cond_t dec_cond(input logic [2:0] f);
		unique case (f)
			3'b010: dec_cond = CODS_CF_CARRY;
			3'b100: dec_cond = CODS_CF_ZERO;
			default: dec_cond = CODS_CF_NONE;
		endcase
	endfunction

	// Full instruction decode from first and second byte
	function automatic cods_dec_t decode(input logic [7:0] b1, input logic [7:0] b2, input logic second);
		cods_dec_t d;
		d = '{reg_sel: CODS_REG_NONE, special_reg_field: CODS_SR_NONE, stack_pair_field: CODS_PR_SP,
			ind_sel: CODS_IND_NONE, irqf_sel: CODS_IF_NONE, cond_sel: CODS_CF_NONE,
			clocks: CODS_CLK_UNK, first_fetch_strobe: 1'b0};
		// strobe only for the first byte
		d.first_fetch_strobe = ~second;
		if (b1[7:3] == CODS_OP_MOV_AR || b1[7:3] == CODS_OP_MOV_RA) begin
			d.reg_sel = dec_reg(b1[2:0]);
			d.clocks  = CODS_CLK_MOV;
		end else if (b1[7:3] == CODS_OP_MVJ) begin
			d.reg_sel = dec_reg(b1[2:0]);
			d.clocks  = CODS_CLK_IMM;
		end else if (b1 == CODS_OP_STORE_WORK_AREA || b1 == CODS_OP_LOAD_WORK_AREA) begin
			d.clocks = CODS_CLK_SR;
		end else if (b1[7:3] == CODS_OP_STX || b1[7:3] == CODS_OP_LDX) begin
			d.ind_sel = dec_ind(b1[2:0]);
			d.clocks  = CODS_CLK_IMM;
		end else if (b1 == CODS_PFX_SRW || b1 == CODS_PFX_SRR) begin
			d.special_reg_field = dec_sr(b2[3:0]);
			d.clocks = CODS_CLK_SR;
		end else if (b1 == CODS_OP_LXI_H || (b1[7:6] == 2'b00 && b1[3:0] == 4'h4)) begin
			d.stack_pair_field = cods_pair_t'({1'b0, b1[5:4]});
			d.clocks = CODS_CLK_LXI;
		end else if (b1 == CODS_PFX_DIR) begin
			if (b2[7:4] == 4'b0110 || b2[7:4] == 4'b0111) begin
				d.reg_sel = dec_reg(b2[2:0]);
				d.clocks = (b2[3] == 1'b1) ? CODS_CLK_DIR : CODS_CLK_UNK;
			end else if (b2[3:1] == 3'b111) begin
				d.stack_pair_field = cods_pair_t'({1'b0, b2[5:4]});
				d.clocks = CODS_CLK_PAIR;
			end else begin
				d.ind_sel = dec_ind(b2[2:0]);
				d.clocks  = CODS_CLK_ALUX;
			end
		end else if (b1 == CODS_PFX_STK) begin
			if (b2[3:1] == 3'b111) begin
				d.stack_pair_field = (b2[5:4] == 2'b00) ? CODS_PR_FFA : cods_pair_t'({1'b0, b2[5:4]});
				d.clocks = b2[0] ? CODS_CLK_POP : CODS_CLK_PUSH;
			end else begin
				d.irqf_sel = dec_irqf(b2[2:0]);
				d.cond_sel = dec_cond(b2[2:0]);
			end
		end else if (b1 == CODS_PFX_ALUR) begin
			d.reg_sel = dec_reg(b2[2:0]);
			d.clocks  = CODS_CLK_ALUR;
		end
		return d;
	endfunction

	logic       acc_grp;
	logic       hl_grp;
	logic       tick;
	logic       wr_ctrl;
	logic       wr_op;
	cods_dec_t  dnew;

	always_comb begin
		s_nxt   = s_r;
		tick    = (s_r.div == CODS_DIV_LAST);
		wr_ctrl = avs_write && avs_address == CODS_OFF_CTRL && avs_byteenable[0];
		wr_op   = avs_write && avs_address == CODS_OFF_OPCODE && s_r.state == CODS_ST_IDLE;
		dnew    = decode(avs_writedata[7:0], avs_writedata[15:8], s_r.ctrl[CODS_CTRL_SECOND_BIT]);
		acc_grp = (avs_writedata[7:0] == CODS_OP_MVI_A);
		hl_grp  = (avs_writedata[7:0] == CODS_OP_MVI_L) || (avs_writedata[7:0] == CODS_OP_LXI_H);
		s_nxt.div = tick ? 2'd0 : s_r.div + 2'd1;
		s_nxt.rvalid = avs_read;
		if (wr_ctrl) begin
			s_nxt.ctrl = avs_writedata[7:0];
		end
		// interrupt entry allowed even while skipping
		// status word holds flags, pushed first
		if (wr_ctrl && avs_writedata[CODS_CTRL_IRQ_BIT]) begin
			s_nxt.saved_flags = {s_r.acc_string_flag, s_r.hl_string_flag};
			s_nxt.irq_seen    = 1'b1;
			s_nxt.state       = CODS_ST_IDLE;
			s_nxt.cnt         = '0;
		end
		if (wr_ctrl && avs_writedata[CODS_CTRL_RETI_BIT] && s_r.irq_seen) begin
			s_nxt.acc_string_flag = s_r.saved_flags[1];
			s_nxt.hl_string_flag  = s_r.saved_flags[0];
			s_nxt.irq_seen        = 1'b0;
		end
		if (wr_op && s_r.ctrl[CODS_CTRL_EN_BIT]) begin
			s_nxt.op1 = avs_writedata[7:0];
			s_nxt.op2 = avs_writedata[15:8];
			s_nxt.dec = dnew;
			s_nxt.cnt = dnew.clocks;
			// repeats of a group become idle slots
			// leaving a group clears its flag
			s_nxt.suppressed      = (acc_grp && s_r.acc_string_flag) || (hl_grp && s_r.hl_string_flag);
			s_nxt.acc_string_flag = acc_grp;
			s_nxt.hl_string_flag  = hl_grp;
			s_nxt.state = s_nxt.suppressed ? CODS_ST_SKIP : CODS_ST_RUN;
		end else if (s_r.state != CODS_ST_IDLE && tick) begin
			// idle slot as long as normal execution
			s_nxt.cnt = s_r.cnt - 5'd1;
			if (s_r.cnt == 5'd1) begin
				s_nxt.state = CODS_ST_IDLE;
			end
		end
		unique case (avs_address)
			CODS_OFF_CTRL:   s_nxt.rdata = s_r.ctrl;
			CODS_OFF_OPCODE: s_nxt.rdata = s_r.op1;
			CODS_OFF_STATUS: s_nxt.rdata = {s_r.state, s_r.suppressed, s_r.irq_seen,
				s_r.saved_flags, s_r.acc_string_flag, s_r.hl_string_flag};
			CODS_OFF_DECODE: s_nxt.rdata = {3'b000, s_r.cnt};
			default:         s_nxt.rdata = 8'h00;
		endcase
		if (sys_rst) begin
			s_nxt = '0;
			s_nxt.ctrl = CODS_CTRL_RST;
		end
	end

	always_ff @(posedge clock) begin
		s_r <= s_nxt;
	end

	// Reads wait one cycle for registered data; writes complete at once
	assign avs_waitrequest = avs_read && !s_r.rvalid;
	assign avs_readdata    = {24'h000000, s_r.rdata};
	assign sys_tick        = tick;
	assign busy            = (s_r.state != CODS_ST_IDLE);
	assign dec_out         = s_r.dec;
endmodule

// [dv/cods_decode_assertions.sv]
// Port-level checker for the opcode decode and string-skip block
module cods_decode_assertions (
	input wire logic                clock,
	input wire logic                sys_rst,
	input wire logic [3:0]          avs_address,
	input wire logic                avs_read,
	input wire logic                avs_write,
	input wire logic [31:0]         avs_writedata,
	input wire logic [3:0]          avs_byteenable,
	input wire logic [31:0]         avs_readdata,
	input wire logic                avs_waitrequest,
	input wire logic                sys_tick,
	input wire logic                busy,
	input wire cods_pkg::cods_dec_t dec_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import cods_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic [15:0] wd;
	logic [5:0]  tick_cnt_r;
	assign wd = avs_writedata[15:0];
	// Ticks seen while busy; an idle slot may not outlast its normal count
	always_ff @(posedge clock) begin
		if (sys_rst || !busy)
			tick_cnt_r <= 6'h00;
		else if (sys_tick)
			tick_cnt_r <= tick_cnt_r + 6'h01;
	end
	tick_period_a: assert property (sys_tick |=> !sys_tick [*3] ##1 sys_tick)
		else $error("system tick not one in four clocks");
	read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 (!avs_waitrequest || !avs_read))
		else $error("read wait state wrong");
	write_nowait_a: assert property (avs_write |-> !avs_waitrequest)
		else $error("write stalled");
	slot_length_a: assert property (busy |-> tick_cnt_r <= {1'b0, dec_out.clocks})
		else $error("busy outlasts clock count");
	mov_decode_a: assert property ($rose(busy) && ($past(wd[7:3]) inside {5'b00001, 5'b00011})
		&& $past(wd[2:1]) != 2'b00
		|-> dec_out.clocks == 5'd4 && dec_out.reg_sel == {1'b0, $past(wd[2:0])})
		else $error("register move decode wrong");
	imm_decode_a: assert property ($rose(busy) && $past(wd[7:3]) == 5'b01101
		|-> dec_out.clocks == 5'd7 && dec_out.reg_sel == {1'b0, $past(wd[2:0])})
		else $error("immediate move decode wrong");
	ind_decode_a: assert property ($rose(busy) && ($past(wd[7:3]) inside {5'b00111, 5'b00101})
		&& $past(wd[2:0]) != 3'h0
		|-> dec_out.clocks == 5'd7 && dec_out.ind_sel == {1'b0, $past(wd[2:0])})
		else $error("indirect decode wrong");
	ten_clock_a: assert property ($rose(busy) && ($past(wd[7:0]) inside {8'h4c, 8'h4d, 8'h38, 8'h28})
		|-> dec_out.clocks == 5'd10) else $error("ten clock group wrong");
	alu_clocks_a: assert property ($rose(busy) && ($past(wd[7:0]) inside {8'h60, 8'h70}) &&
		($past(wd[15:11]) inside {5'b11000, 5'b11010, 5'b11100}) |-> dec_out.clocks == ($past(wd[4]) ? 5'd11 : 5'd8))
		else $error("arithmetic clock count wrong");
endmodule

bind cods_decode cods_decode_assertions i_cods_decode_assertions (.clock, .sys_rst, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .sys_tick, .busy, .dec_out);

// [dv/cods_prog_mem.sv]
// Program store feeding the immediate-load string sequence
module cods_prog_mem (
	output logic [15:0] prog [8]
);
	timeunit 1ns;
	timeprecision 1ns;
	// Accumulator run, L/HL mix with a pair load, then a fresh accumulator load
	assign prog = '{16'h0069, 16'h0169, 16'h0269, 16'h0a6f, 16'h0b6f, 16'h0c6f, 16'h0034, 16'h0369};
endmodule

// [dv/test_cpu_opcode_decode_and_string_skip.sv]
// Self-checking bench for the opcode decode and string-skip block
module test_cpu_opcode_decode_and_string_skip;
	timeunit 1ns;
	timeprecision 1ns;
	import cods_pkg::*;
	logic        clock, sys_rst, avs_read, avs_write, avs_waitrequest, sys_tick, busy;
	logic [3:0]  avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rd, r;
	logic [15:0] x;
	logic [15:0] prog [8];
	logic [2:0]  f;
	cods_dec_t   dec_out;
	int          fail_count, num_checks, seed, ticks, k;
	logic [15:0] tmpl [16] = '{16'h0008, 16'h0018, 16'h0068, 16'h0028, 16'h0038, 16'hc060, 16'hc070, 16'h6870,
		16'hc04d, 16'hc04c, 16'h1e48, 16'h1f48, 16'h1e70, 16'h7870, 16'hd260, 16'h0034};
	// Flag mask in [3:2], expected flags in [1:0]
	logic [3:0]  fl [8] = '{4'he, 4'he, 4'he, 4'hd, 4'hd, 4'h0, 4'hd, 4'he};
	// Steps of the string sequence that must turn into idle slots
	logic [7:0]  supp = 8'h56;

	cods_decode i_cods_decode (.clock, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .sys_tick, .busy, .dec_out);
	cods_prog_mem i_cods_prog_mem (.prog);

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		if (fail_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Hold the request until waitrequest is sampled low, then release and idle one edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		check("bus_wait", n < 20, 1);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clock);
	endtask

	task automatic op(input logic [15:0] word, input logic wt);
		int n;
		bus(1'b1, CODS_OFF_OPCODE, {16'h0, word});
		ticks = 0;
		n = 0;
		while (wt && busy !== 1'b0 && n < 200) begin
			if (sys_tick === 1'b1)
				ticks++;
			n++;
			@(posedge clock);
		end
	endtask

	function automatic logic [4:0] exp_clk(input logic [15:0] w);
		if (w[7:0] inside {8'h4d, 8'h4c, 8'h38, 8'h28, 8'h34})
			return 5'd10;
		if (w[7:0] == 8'h60)
			return 5'd8;
		if (w[7:0] == 8'h48)
			return w[8] ? 5'd14 : 5'd17;
		if (w[7:0] == 8'h70)
			return w[15] ? 5'd11 : (w[14] ? 5'd17 : 5'd20);
		if (w[7:3] inside {5'b01101, 5'b00111, 5'b00101})
			return 5'd7;
		return 5'd4;
	endfunction

	function automatic logic [3:0] exp_sr(input logic [3:0] c);
		return (c inside {4'h5, 4'h7} || c > 4'hb) ? CODS_SR_NONE : c;
	endfunction

	function automatic logic [2:0] exp_irqf(input logic [2:0] c);
		return (c inside {3'h0, 3'h1, 3'h2, 3'h4}) ? c : CODS_IF_NONE;
	endfunction

	function automatic logic [1:0] exp_cond(input logic [2:0] c);
		return (c == 3'h2) ? CODS_CF_CARRY : ((c == 3'h4) ? CODS_CF_ZERO : CODS_CF_NONE);
	endfunction

	initial begin
		seed = 55342;
		fail_count = 0;
		num_checks = 0;
		sys_rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		check("dec_out", 32'(dec_out), 32'h0);
		for (int a = 0; a < 16; a += 2) begin
			bus(1'b0, 4'(a), 32'h0);
			check("reset_read", rd, 32'h0);
		end
		op(16'h000a, 1'b1);
		check("refused", 32'(dec_out.clocks), 32'h0);
		bus(1'b1, CODS_OFF_CTRL, 32'h1);
		for (int i = 0; i < 64; i++) begin
			r = $random(seed);
			k = (i < 16) ? i : int'(r[7:4]);
			f = (k < 3) ? 3'd2 + 3'(r[15:8] % 6) : r[2:0];
			x = tmpl[k] | ((k < 5) ? {13'h0, f} : ((k < 8) ? {5'h0, f, 8'h0} : 16'h0));
			op(x, 1'b1);
			check("ticks", ticks, exp_clk(x));
			check("dec_clocks", dec_out.clocks, exp_clk(x));
			check("strobe", dec_out.first_fetch_strobe, 1);
		end
		bus(1'b1, CODS_OFF_CTRL, 32'h9);
		op(16'h000b, 1'b1);
		check("strobe2", dec_out.first_fetch_strobe, 0);
		bus(1'b1, CODS_OFF_CTRL, 32'h1);
		// Walk every code of the selector fields
		for (int j = 0; j < 16; j++) begin
			op({4'h0, j[3:0], 8'h4d} | 16'hc000, 1'b1);
			check("sr_field", dec_out.special_reg_field, exp_sr(j[3:0]));
			if (j < 8) begin
				op({5'b00010, j[2:0], 8'h48}, 1'b1);
				check("irqf_sel", dec_out.irqf_sel, exp_irqf(j[2:0]));
				check("cond_sel", dec_out.cond_sel, exp_cond(j[2:0]));
			end
			if (j < 4) begin
				op({8'h00, 2'b00, j[1:0], 4'h4}, 1'b1);
				check("lxi_pair", dec_out.stack_pair_field, {1'b0, j[1:0]});
				op({2'b00, j[1:0], 4'he, 8'h48}, 1'b1);
				check("push_pair", dec_out.stack_pair_field, (j == 0) ? CODS_PR_FFA : {1'b0, j[1:0]});
			end
		end
		for (int s = 0; s < 8; s++) begin
			op(prog[s], s != 5);
			if (s == 5) begin
				bus(1'b1, CODS_OFF_CTRL, 32'h3);
				bus(1'b0, CODS_OFF_STATUS, 32'h0);
				check("irq_seen", rd[4], 1);
				check("saved", rd[3:2], 2'b01);
				// Service routine clears both flags, so only the return can bring them back
				op(16'h000a, 1'b1);
				bus(1'b1, CODS_OFF_CTRL, 32'h5);
				bus(1'b0, CODS_OFF_STATUS, 32'h0);
				check("restored", rd[1:0], 2'b01);
			end else begin
				check("slot_ticks", ticks, exp_clk(prog[s]));
				bus(1'b0, CODS_OFF_STATUS, 32'h0);
				check("flags", rd[1:0] & fl[s][3:2], fl[s][1:0]);
				check("suppressed", rd[5], supp[s]);
			end
		end
		report_and_stop();
	end

	initial begin
		repeat (30000) @(posedge clock);
		fail_count++;
		report_and_stop();
	end
endmodule
